// *** hdl/mdio_controller_end.sv ***
// management controller end: makes mdc and runs one frame per request
`timescale 1ns/1ps
module mdio_controller_end #(
	parameter int MDC_HALF = mdio_pkg::MDC_HALF_DEFAULT
) (
	input wire logic core_clk,
	input wire logic nrst,
	mdio_link_if.ctl link,
	input wire logic start,
	input wire logic read,
	input wire logic [4:0] phy_addr,
	input wire logic [4:0] reg_addr,
	input wire logic [mdio_pkg::DATA_W-1:0] wr_data,
	output logic busy,
	output logic done,
	output logic [mdio_pkg::DATA_W-1:0] rd_data
);
	import mdio_pkg::*;

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	ctl_state_type state_reg;
	logic [7:0] div_reg;
	logic mdc_reg;
	logic [63:0] frame_reg;
	logic [5:0] cnt_reg;
	logic rd_reg, out_reg, oe_reg, done_reg;
	logic mdio_s1_reg, mdio_s2_reg;
	logic [15:0] rd_shift_reg, rd_data_reg;
	logic tick, rise, fall;

	// ----------------------------------------------------------------
	// clock divider; mdc stays low between frames
	// ----------------------------------------------------------------
	assign tick = (state_reg == ctl_run) && (div_reg == 8'(MDC_HALF - 1));
	assign rise = tick & ~mdc_reg;
	assign fall = tick & mdc_reg;

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			div_reg <= 8'h00;
			mdc_reg <= 1'b0;
		end else if (state_reg != ctl_run || tick) begin
			div_reg <= 8'h00;
			mdc_reg <= (state_reg == ctl_run) ? ~mdc_reg : 1'b0;
		end else begin
			div_reg <= div_reg + 8'h01;
		end
	end

	// data line input, two stages before use
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			mdio_s1_reg <= 1'b1;
			mdio_s2_reg <= 1'b1;
		end else begin
			mdio_s1_reg <= link.mdio;
			mdio_s2_reg <= mdio_s1_reg;
		end
	end

	// ----------------------------------------------------------------
	// frame sequencer: bits change on mdc fall, sampled by far end on rise
	// ----------------------------------------------------------------
	// R1: preamble, start and opcode
	// R2: release line from first turnaround bit of a read
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			state_reg <= ctl_idle;
			frame_reg <= 64'h0;
			cnt_reg <= 6'h00;
			rd_reg <= 1'b0;
			out_reg <= 1'b1;
			oe_reg <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			done_reg <= 1'b0;
			case (state_reg)
				ctl_idle: begin
					if (start) begin
						frame_reg <= {32'hffffffff, START_PATTERN, read ? OP_READ : OP_WRITE,
							phy_addr, reg_addr, read ? 2'b11 : 2'b10, read ? 16'hffff : wr_data};
						cnt_reg <= 6'h00;
						rd_reg <= read;
						out_reg <= 1'b1;
						oe_reg <= 1'b1;
						state_reg <= ctl_run;
					end
				end
				ctl_run: begin
					if (fall) begin
						if (cnt_reg == FRAME_LAST) begin
							oe_reg <= 1'b0;
							out_reg <= 1'b1;
							done_reg <= 1'b1;
							state_reg <= ctl_idle;
						end else begin
							cnt_reg <= cnt_reg + 6'h01;
							out_reg <= frame_reg[62];
							frame_reg <= {frame_reg[62:0], 1'b1};
							oe_reg <= ~(rd_reg && (cnt_reg + 6'h01 >= FRAME_TA_FIRST));
						end
					end
				end
				default: begin
					state_reg <= ctl_idle;
				end
			endcase
		end
	end

	// read data capture on mdc rise
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			rd_shift_reg <= DATA_RESET;
			rd_data_reg <= DATA_RESET;
		end else begin
			if (rise && rd_reg && cnt_reg >= FRAME_DATA_FIRST) begin
				rd_shift_reg <= {rd_shift_reg[14:0], mdio_s2_reg};
			end
			if (fall && cnt_reg == FRAME_LAST && rd_reg) begin
				rd_data_reg <= rd_shift_reg;
			end
		end
	end

	// R13: controller alone drives mdc
	assign link.mdc = mdc_reg;
	assign link.ctl_mdio_o = out_reg;
	assign link.ctl_mdio_oe = oe_reg;
	assign busy = (state_reg == ctl_run);
	assign done = done_reg;
	assign rd_data = rd_data_reg;

endmodule

// *** hdl/mdio_device_end.sv ***
// management slave end: decodes frames and issues register accesses
`timescale 1ns/1ps

// Behaviour
// R1: frame is 32 ones, 01, opcode 10/01
// R2: read: TA released then zero, data MSB first
// R3: address bit 2 clear selects standard registers
// R4: standard access ignores address bits 4:3
// R5: standard access reaches sixteen-bit registers 0..5
// R6: address bit 2 set selects extended access
// R7: extended access ignores address bits 1:0
// R8: extended address is phy[4:3] and register field
// R9: extended read returns zero upper byte
// R10: extended write keeps only low byte
// R11: extended space spans 0..127, standard reachable indirectly
// R12: extended frames share framing, turnaround, bit order
// R13: clock from controller, one shared data line
// R14: sample on rising edge, drive only read
// R15: bad start or opcode waits new preamble
module mdio_device_end (
	input wire logic core_clk,
	input wire logic nrst,
	mdio_link_if.dev link,
	output logic acc_req,
	output logic acc_write,
	output logic acc_ext,
	output logic [mdio_pkg::ADDR_W-1:0] acc_addr,
	output logic [mdio_pkg::DATA_W-1:0] acc_wdata,
	input wire logic [mdio_pkg::DATA_W-1:0] acc_rdata
);
	import mdio_pkg::*;

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic mdc_s1_reg, mdc_s2_reg, mdc_s3_reg;
	logic mdio_s1_reg, mdio_s2_reg;
	logic rise, bit_in;
	dev_state_type state_reg;
	logic [5:0] cnt_reg;
	logic [15:0] shift_reg;
	logic op_rd_reg;
	logic [4:0] phy_reg;
	logic ext_reg, hit_reg;
	logic [4:0] reg_now;
	logic [ADDR_W-1:0] addr_now;
	logic hit_now;
	logic [15:0] tx_reg;
	logic out_reg, oe_reg;
	logic req_reg, write_reg, ext_out_reg;
	logic [ADDR_W-1:0] addr_reg;
	logic [15:0] wdata_reg;
	logic addr_done, data_done;

	// true when a standard register number names one of the six
	function automatic logic std_hit(input logic [4:0] regno);
		std_hit = (regno < STD_REG_COUNT);
	endfunction

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	// R13: clock comes only from the far end
	// two stages per pin; the third mdc stage only feeds the edge finder
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			mdc_s1_reg <= 1'b0;
			mdc_s2_reg <= 1'b0;
			mdc_s3_reg <= 1'b0;
			mdio_s1_reg <= 1'b1;
			mdio_s2_reg <= 1'b1;
		end else begin
			mdc_s1_reg <= link.mdc;
			mdc_s2_reg <= mdc_s1_reg;
			mdc_s3_reg <= mdc_s2_reg;
			mdio_s1_reg <= link.mdio;
			mdio_s2_reg <= mdio_s1_reg;
		end
	end

	// R14: sample on mdc rise
	assign rise = mdc_s2_reg & ~mdc_s3_reg;
	assign bit_in = mdio_s2_reg;

	// ----------------------------------------------------------------
	// address decode of the field being completed
	// ----------------------------------------------------------------
	assign reg_now = {shift_reg[3:0], bit_in};
	assign addr_done = rise && (state_reg == st_reg) && (cnt_reg == FIELD_LAST);
	assign data_done = rise && (state_reg == st_data) && (cnt_reg == DATA_LAST);

	// R3: bit 2 clear is standard
	// R6: bit 2 set is extended
	// R4: standard ignores bits 4:3
	// R7: extended ignores bits 1:0
	// R8: extended address concatenation
	// R11: full 0..127 in extended
	always_comb begin
		if (phy_reg[PHY_EXT_BIT]) begin
			addr_now = {phy_reg[4:3], reg_now};
			hit_now = 1'b1;
		end else begin
			addr_now = {2'b00, reg_now};
			hit_now = std_hit(reg_now);
		end
	end

	// ----------------------------------------------------------------
	// frame decoder
	// ----------------------------------------------------------------
	// R12: one decoder serves both access kinds
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			state_reg <= st_pre;
			cnt_reg <= 6'h00;
			shift_reg <= DATA_RESET;
			op_rd_reg <= 1'b0;
			phy_reg <= 5'h00;
			ext_reg <= 1'b0;
			hit_reg <= 1'b0;
		end else if (rise) begin
			shift_reg <= {shift_reg[14:0], bit_in};
			cnt_reg <= cnt_reg + 6'h01;
			case (state_reg)
				st_pre: begin
					// R1: count preamble ones
					if (bit_in) begin
						cnt_reg <= (cnt_reg == PREAMBLE_LEN) ? cnt_reg : cnt_reg + 6'h01;
					end else if (cnt_reg == PREAMBLE_LEN) begin
						state_reg <= st_start;
						cnt_reg <= 6'h00;
					end else begin
						cnt_reg <= 6'h00;
					end
				end
				st_start: begin
					cnt_reg <= 6'h00;
					// R15: bad start abandons frame
					state_reg <= ({1'b0, bit_in} == START_PATTERN) ? st_op : st_pre;
				end
				st_op: begin
					if (cnt_reg == OP_LAST) begin
						cnt_reg <= 6'h00;
						// R15: unknown opcode abandons frame
						if ({shift_reg[0], bit_in} == OP_READ || {shift_reg[0], bit_in} == OP_WRITE) begin
							op_rd_reg <= ({shift_reg[0], bit_in} == OP_READ);
							state_reg <= st_phy;
						end else begin
							state_reg <= st_pre;
						end
					end
				end
				st_phy: begin
					if (cnt_reg == FIELD_LAST) begin
						phy_reg <= {shift_reg[3:0], bit_in};
						cnt_reg <= 6'h00;
						state_reg <= st_reg;
					end
				end
				st_reg: begin
					if (cnt_reg == FIELD_LAST) begin
						ext_reg <= phy_reg[PHY_EXT_BIT];
						hit_reg <= hit_now;
						cnt_reg <= 6'h00;
						state_reg <= st_ta;
					end
				end
				st_ta: begin
					if (cnt_reg == TA_LAST) begin
						cnt_reg <= 6'h00;
						state_reg <= st_data;
					end
				end
				st_data: begin
					// a fresh preamble is needed after every frame
					if (cnt_reg == DATA_LAST) begin
						cnt_reg <= 6'h00;
						state_reg <= st_pre;
					end
				end
				default: begin
					cnt_reg <= 6'h00;
					state_reg <= st_pre;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// data line drive
	// ----------------------------------------------------------------
	// R14: drive only the second turnaround bit and read data
	// output changes just after the rise, so it is stable at the next one
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			out_reg <= 1'b1;
			oe_reg <= 1'b0;
			tx_reg <= DATA_RESET;
		end else if (rise && op_rd_reg) begin
			if (state_reg == st_ta && cnt_reg == 6'h00) begin
				// R2: zero on second turnaround bit
				out_reg <= 1'b0;
				oe_reg <= 1'b1;
				// R9: upper byte zero on extended read
				// R5: unmapped standard numbers read as zero
				if (!hit_reg) begin
					tx_reg <= DATA_RESET;
				end else if (ext_reg) begin
					tx_reg <= {8'h00, acc_rdata[CFG_W-1:0]};
				end else begin
					tx_reg <= acc_rdata;
				end
			end else if (state_reg == st_ta || (state_reg == st_data && cnt_reg != DATA_LAST)) begin
				// R2: most significant bit first
				out_reg <= tx_reg[15];
				tx_reg <= {tx_reg[14:0], 1'b0};
			end else if (state_reg == st_data) begin
				out_reg <= 1'b1;
				oe_reg <= 1'b0;
			end
		end
	end

	assign link.dev_mdio_o = out_reg;
	assign link.dev_mdio_oe = oe_reg;

	// ----------------------------------------------------------------
	// access requests to the register side
	// ----------------------------------------------------------------
	// reads are requested one bit early so the data is ready at turnaround
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			req_reg <= 1'b0;
			write_reg <= 1'b0;
			ext_out_reg <= 1'b0;
			addr_reg <= 7'h00;
			wdata_reg <= DATA_RESET;
		end else begin
			req_reg <= 1'b0;
			// R5: only standard registers 0..5 are requested; every extended address is requested
			if (addr_done) begin
				addr_reg <= addr_now;
				ext_out_reg <= phy_reg[PHY_EXT_BIT];
				write_reg <= ~op_rd_reg;
				req_reg <= op_rd_reg & hit_now;
			end
			if (data_done && !op_rd_reg) begin
				// R10: extended write keeps low byte
				wdata_reg <= ext_reg ? {8'h00, shift_reg[6:0], bit_in} : {shift_reg[14:0], bit_in};
				req_reg <= hit_reg;
			end
		end
	end

	assign acc_req = req_reg;
	assign acc_write = write_reg;
	assign acc_ext = ext_out_reg;
	assign acc_addr = addr_reg;
	assign acc_wdata = wdata_reg;

endmodule

// *** hdl/mdio_link_if.sv ***
// two-wire management link joining the controller end and the device end
`timescale 1ns/1ps
interface mdio_link_if;
	logic mdc;
	logic ctl_mdio_o;
	logic ctl_mdio_oe;
	logic dev_mdio_o;
	logic dev_mdio_oe;
	logic mdio;

	// resolved data line; the pull-up holds it high when nobody drives
	assign mdio = ctl_mdio_oe ? ctl_mdio_o : (dev_mdio_oe ? dev_mdio_o : 1'b1);

	modport ctl (output mdc, output ctl_mdio_o, output ctl_mdio_oe, input mdio);
	modport dev (input mdc, input mdio, output dev_mdio_o, output dev_mdio_oe);
endinterface

// *** hdl/mdio_pkg.sv ***
// shared constants and types for the two-wire management link
package mdio_pkg;

	// ----------------------------------------------------------------
	// frame layout
	// ----------------------------------------------------------------
	localparam logic [5:0] PREAMBLE_LEN = 6'h20;
	localparam logic [1:0] OP_READ = 2'b10;
	localparam logic [1:0] OP_WRITE = 2'b01;
	localparam logic [1:0] START_PATTERN = 2'b01;
	localparam logic [5:0] FIELD_LAST = 6'h04;
	localparam logic [5:0] OP_LAST = 6'h01;
	localparam logic [5:0] TA_LAST = 6'h01;
	localparam logic [5:0] DATA_LAST = 6'h0f;
	localparam logic [5:0] FRAME_LAST = 6'h3f;
	localparam logic [5:0] FRAME_TA_FIRST = 6'h2e;
	localparam logic [5:0] FRAME_DATA_FIRST = 6'h30;

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	localparam int PHY_EXT_BIT = 2;
	localparam logic [4:0] STD_REG_COUNT = 5'h06;
	localparam int ADDR_W = 7;
	localparam int DATA_W = 16;
	localparam int CFG_W = 8;

	// ----------------------------------------------------------------
	// reset values and clock divider
	// ----------------------------------------------------------------
	localparam logic [15:0] DATA_RESET = 16'h0000;
	localparam int MDC_HALF_DEFAULT = 6;

	typedef enum logic [2:0] {
		st_pre, st_start, st_op, st_phy, st_reg, st_ta, st_data
	} dev_state_type;

	typedef enum logic {
		ctl_idle, ctl_run
	} ctl_state_type;

endpackage

// *** sim/mdio_link_chk.sv ***
// concurrent checks on the two-wire management link
`timescale 1ns/1ps
module mdio_link_chk
	import mdio_pkg::*;
#(
	parameter int MDC_HALF = 6
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic mdc,
	input wire logic ctl_mdio_o,
	input wire logic ctl_mdio_oe,
	input wire logic dev_mdio_o,
	input wire logic dev_mdio_oe,
	input wire logic mdio
);
	logic mdc_q;
	logic ctl_oe_q;
	logic [6:0] rise_cnt;
	logic [7:0] hi_cnt;
	logic [9:0] oe_cnt;

	// -------------------------------------------------------------
	// helper counters
	// -------------------------------------------------------------
	// edge history for rise and frame-start detection
	always_ff @(posedge core_clk) begin
		mdc_q <= mdc;
		ctl_oe_q <= ctl_mdio_oe;
	end
	// clock rises since the controller took the line; restarts each frame
	always_ff @(posedge core_clk) begin
		if (!nrst || (ctl_mdio_oe && !ctl_oe_q)) begin
			rise_cnt <= 7'h00;
		end else if (mdc && !mdc_q) begin
			rise_cnt <= rise_cnt + 7'h01;
		end
	end
	// length of the current high phase and of the device drive window
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			hi_cnt <= 8'h00;
			oe_cnt <= 10'h000;
		end else begin
			hi_cnt <= mdc ? hi_cnt + 8'h01 : 8'h00;
			oe_cnt <= dev_mdio_oe ? oe_cnt + 10'h001 : 10'h000;
		end
	end

	// -------------------------------------------------------------
	// assertions
	// -------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	// the 33rd rise of a frame carries the first start bit
	sequence pre_done_s;
		$rose(mdc) && ctl_mdio_oe && rise_cnt == 7'h20;
	endsequence

	no_contend_a: assert property (!(ctl_mdio_oe && dev_mdio_oe))
		else $error("both ends drive the data line");
	pre_ones_a: assert property ($rose(mdc) && ctl_mdio_oe && rise_cnt < 7'h20 |-> mdio)
		else $error("preamble bit not one");
	start_bits_a: assert property (pre_done_s |-> !mdio ##[1:20] ($rose(mdc) && mdio))
		else $error("start pattern not 01");
	frame_len_a: assert property ($fell(ctl_mdio_oe) |-> rise_cnt == 7'h2e || rise_cnt == 7'h40)
		else $error("controller released at wrong bit");
	ta_zero_a: assert property ($rose(dev_mdio_oe) |-> !dev_mdio_o && mdc && rise_cnt == 7'h2f)
		else $error("device drive start wrong");
	dev_change_a: assert property ($changed(dev_mdio_o) |-> mdc)
		else $error("device bit changed in low phase");
	ctl_change_a: assert property ($changed(ctl_mdio_o) |-> !mdc)
		else $error("controller bit changed in high phase");
	hi_phase_a: assert property ($fell(mdc) |-> hi_cnt == MDC_HALF)
		else $error("clock high phase wrong length");
	dev_span_a: assert property ($fell(dev_mdio_oe) |-> oe_cnt inside {[34*MDC_HALF-1:34*MDC_HALF+1]})
		else $error("device drive window not 17 bits");
endmodule

// *** sim/mdio_register_access_slave_tb_top.sv ***
// self-checking bench: controller end and device end joined over the link
`timescale 1ns/1ps
module mdio_register_access_slave_tb_top;
	import mdio_pkg::*;
	logic core_clk = 1'b0;
	logic nrst = 1'b0;
	logic start = 1'b0;
	logic read = 1'b0;
	logic [4:0] phy_addr = 5'h00;
	logic [4:0] reg_addr = 5'h00;
	logic [15:0] wr_data = 16'h0000;
	logic busy;
	logic done;
	logic [15:0] rd_data;
	logic acc_req;
	logic acc_write;
	logic acc_ext;
	logic [6:0] acc_addr;
	logic [15:0] acc_wdata;
	logic [15:0] acc_rdata = 16'h0000;
	logic acc2_req;
	logic [6:0] acc2_addr;
	logic [15:0] acc2_wdata;
	logic [15:0] mem [0:255];
	logic ta_bit = 1'b1;
	int errors = 0;
	int n_checks = 0;
	int oe_rises = 0;
	int req2_cnt = 0;
	int drive2_cnt = 0;

	mdio_link_if link ();
	mdio_link_if link2 ();

	always #5 core_clk = ~core_clk;

	mdio_controller_end #(.MDC_HALF(6)) u_mdio_controller_end (.core_clk(core_clk), .nrst(nrst), .link(link.ctl),
		.start(start), .read(read), .phy_addr(phy_addr), .reg_addr(reg_addr), .wr_data(wr_data), .busy(busy),
		.done(done), .rd_data(rd_data));
	mdio_device_end u_mdio_device_end (.core_clk(core_clk), .nrst(nrst), .link(link.dev), .acc_req(acc_req),
		.acc_write(acc_write), .acc_ext(acc_ext), .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_rdata(acc_rdata));
	// second device end, driven by a hand-made controller that breaks framing
	mdio_device_end u_mdio_device_end_2 (.core_clk(core_clk), .nrst(nrst), .link(link2.dev), .acc_req(acc2_req),
		.acc_write(), .acc_ext(), .acc_addr(acc2_addr), .acc_wdata(acc2_wdata), .acc_rdata(16'h0000));
	mdio_link_chk #(.MDC_HALF(6)) u_mdio_link_chk (.core_clk(core_clk), .nrst(nrst), .mdc(link.mdc),
		.ctl_mdio_o(link.ctl_mdio_o), .ctl_mdio_oe(link.ctl_mdio_oe), .dev_mdio_o(link.dev_mdio_o),
		.dev_mdio_oe(link.dev_mdio_oe), .mdio(link.mdio));

	// -------------------------------------------------------------
	// register side stand-in and wire watchers
	// -------------------------------------------------------------
	// extended reads get a dirty upper byte so the device must clear it
	always @(posedge core_clk) begin
		if (acc_req === 1'b1 && acc_write === 1'b1) begin
			mem[{acc_ext, acc_addr}] <= acc_wdata;
		end
		if (acc2_req === 1'b1) begin
			req2_cnt <= req2_cnt + 1;
		end
	end
	always @(negedge core_clk) begin
		acc_rdata <= mem[{acc_ext, acc_addr}] | (acc_ext ? 16'ha500 : 16'h0000);
	end
	// device drive seen at the controller's sampling edge
	always @(posedge link.mdc) begin
		if (link.dev_mdio_oe === 1'b1) begin
			if (oe_rises == 0) begin
				ta_bit = link.mdio;
			end
			oe_rises++;
		end
	end
	always @(posedge link2.dev_mdio_oe) drive2_cnt++;

	// -------------------------------------------------------------
	// tasks
	// -------------------------------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one frame through the controller end; bounded wait for done
	task automatic op(input logic rd, input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] wd);
		@(negedge core_clk);
		oe_rises = 0;
		ta_bit = 1'b1;
		start = 1'b1;
		read = rd;
		phy_addr = pa;
		reg_addr = ra;
		wr_data = wd;
		@(negedge core_clk);
		start = 1'b0;
		chk({15'h0000, busy}, 16'h0001);
		for (int i = 0; i < 2000; i++) begin
			@(negedge core_clk);
			if (done === 1'b1) break;
		end
		chk({15'h0000, done}, 16'h0001);
		chk({15'h0000, busy}, 16'h0000);
	endtask

	// raw bits on the second link, msb first, 125 ns link clock
	// starts 1 ns past a falling edge so no pin moves on a sampling edge,
	// and ends on a falling edge so back-to-back calls never retoggle oe at once
	task automatic tx(input logic [63:0] bits, input int n);
		@(negedge core_clk);
		#1 link2.ctl_mdio_oe = 1'b1;
		for (int i = n - 1; i >= 0; i--) begin
			link2.ctl_mdio_o = bits[i];
			#62.5 link2.mdc = 1'b1;
			#62.5 link2.mdc = 1'b0;
		end
		link2.ctl_mdio_oe = 1'b0;
		@(negedge core_clk);
	endtask

	task automatic results();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// -------------------------------------------------------------
	// tests
	// -------------------------------------------------------------
	initial begin
		link2.mdc = 1'b0;
		link2.ctl_mdio_o = 1'b1;
		link2.ctl_mdio_oe = 1'b0;
		for (int i = 0; i < 256; i++) begin
			mem[i] = 16'h0000;
		end
		repeat (10) @(negedge core_clk);
		nrst = 1'b1;
		// upper address bits differ between write and read
		op(1'b0, 5'h18, 5'h03, 16'h1234);
		chk(16'(oe_rises), 16'h0000);
		chk(mem[8'h03], 16'h1234);
		chk({15'h0000, acc_write}, 16'h0001);
		op(1'b1, 5'h00, 5'h03, 16'h0000);
		chk(rd_data, 16'h1234);
		chk({15'h0000, acc_write}, 16'h0000);
		chk(16'(oe_rises), 16'h0011);
		chk({15'h0000, ta_bit}, 16'h0000);
		// all standard registers plus the first unmapped number
		for (int i = 0; i < 7; i++) begin
			op(1'b0, 5'(i << 3), 5'(i), 16'hc0f0 + 16'(i));
			op(1'b1, 5'h18 ^ 5'(i << 3), 5'(i), 16'h0000);
			chk(rd_data, (i < 6) ? 16'hc0f0 + 16'(i) : 16'h0000);
		end
		// extended space at both ends, low address bits flipped between accesses
		for (int k = 0; k < 2; k++) begin
			op(1'b0, (k ? 5'h1c : 5'h04) | 5'h03, k ? 5'h1f : 5'h00, k ? 16'hff3c : 16'hff5a);
			chk(mem[k ? 8'hff : 8'h80], k ? 16'h003c : 16'h005a);
			op(1'b1, k ? 5'h1c : 5'h04, k ? 5'h1f : 5'h00, 16'h0000);
			chk(rd_data, k ? 16'h003c : 16'h005a);
		end
		// bad opcode, then a frame without fresh preamble, then a proper one
		tx(64'h0000000f_fffffff7, 36);
		tx(64'h00000000_5a061234, 32);
		repeat (20) @(negedge core_clk);
		chk(16'(req2_cnt), 16'h0000);
		tx(64'hffffffff_5a061234, 64);
		repeat (20) @(negedge core_clk);
		chk(16'(req2_cnt), 16'h0001);
		chk({9'h000, acc2_addr}, 16'h0041);
		chk(acc2_wdata, 16'h0034);
		chk(16'(drive2_cnt), 16'h0000);
		results();
	end

	// watchdog well beyond the expected run length
	initial begin
		#400000;
		errors++;
		results();
	end
endmodule
